// file: logic/rtc_core.sv
// Purpose: Calendar clock with alarm comparator behind an APB slave.
// Assumes: Software keeps to the stop handshakes before loading fields.
// Notes:   Time is kept in binary 24-hour form and coded on each access.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"
module rtc_core
    import rtc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `RTC_TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave.
    input  wire rtc_apb_req_t apb_req,
    output var rtc_apb_rsp_t  apb_rsp,
    // Events.
    output logic              seconds_event,
    output logic              alarm_event
);
    rtc_state_t st;
    rtc_state_t next_st;
    logic       tick;
    logic       run;
    logic [7:0] e_sec;
    logic [7:0] e_min;
    logic [7:0] e_hr;
    logic [7:0] e_day;
    logic [7:0] e_mon;
    logic [7:0] e_year;
    logic [7:0] e_cent;
    logic [4:0] hr_mod;
    logic [5:0] hr_code;
    logic [5:0] mlen;
    logic [7:0] idx;
    logic       hit;
    logic       setup;
    logic       wr;
    logic       wr_time;
    logic       match;
    logic [15:0] v_tsm;
    logic [15:0] v_thw;
    logic [15:0] v_tmd;
    logic [15:0] v_tyr;
    logic [15:0] v_ctl;

    // Binary value to register coding; BCD keeps tens in the upper nibble.
    function automatic logic [7:0] enc(input logic [6:0] v,
                                       input logic b);
        logic [6:0] t;
        logic [6:0] u;
        t = v / 7'h0A;
        u = v % 7'h0A;
        enc = b ? {t[3:0], u[3:0]} : {1'b0, v};
    endfunction : enc

    function automatic logic [6:0] dec(input logic [7:0] v,
                                       input logic b);
        logic [6:0] t;
        t = 7'({3'h0, v[7:4]} * 7'h0A);
        dec = b ? 7'(t + {3'h0, v[3:0]}) : v[6:0];
    endfunction : dec

    function automatic logic [5:0] days_in(input logic [4:0] m,
                                           input logic [6:0] y);
        case (m)
            5'h02:   days_in = (y[1:0] == 2'h0) ? 6'h1D : 6'h1C;
            5'h04, 5'h06, 5'h09, 5'h0B: days_in = 6'h1E;
            default: days_in = 6'h1F;
        endcase
    endfunction : days_in

    // Halting either enable freezes the second counter once any tick already registered has landed.
    assign run = st.count_enable && !st.stop;

    rtc_tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run),
        .tick    (tick)
    );

    // Register views as software sees them in the current coding.
    always_comb begin
        e_sec  = enc(st.sec, st.bcd);
        e_min  = enc(st.min, st.bcd);
        e_day  = enc({1'b0, st.day}, st.bcd);
        e_mon  = enc({2'h0, st.mon}, st.bcd);
        e_year = enc(st.year, st.bcd);
        e_cent = enc(`RTC_CENTURY, st.bcd);
        hr_mod = (st.hr >= `RTC_HR_NOON) ? st.hr - `RTC_HR_NOON : st.hr;
        if (st.twelve) begin
            if (hr_mod == 5'h00) begin
                hr_mod = `RTC_HR_NOON;
            end
            e_hr = enc({2'h0, hr_mod}, st.bcd);
            hr_code = {st.hr >= `RTC_HR_NOON, e_hr[4:0]};
        end else begin
            e_hr = enc({2'h0, st.hr}, st.bcd);
            hr_code = {st.bcd & e_hr[5], e_hr[4:0]};
        end
        v_tsm = '0;
        v_tsm[`RTC_F_SEC] = e_sec[6:0];
        v_tsm[`RTC_F_MIN] = e_min[6:0];
        v_thw = '0;
        v_thw[5:0] = hr_code;
        v_thw[`RTC_F_WDAY] = st.wday;
        v_tmd = '0;
        v_tmd[`RTC_F_DAY] = e_day[5:0];
        v_tmd[`RTC_F_MON] = e_mon[4:0];
        v_tyr = '0;
        v_tyr[`RTC_F_YEAR] = e_year;
        v_tyr[`RTC_F_CENT] = e_cent[5:0];
        v_ctl = '0;
        v_ctl[`RTC_B_BCD]      = st.bcd;
        v_ctl[`RTC_B_TWELVE]   = st.twelve;
        v_ctl[`RTC_B_STOP]     = st.stop;
        v_ctl[`RTC_B_STOPPED]  = st.stopped;
        v_ctl[`RTC_B_ASTOP]    = st.alm_stop;
        v_ctl[`RTC_B_ASTOPPED] = st.alm_stopped;
    end

    // Alarm comparison against the coded view; all ones means any value.
    always_comb begin
        match = 1'b1;
        if (st.alm_sm[`RTC_F_SEC] != 7'h7F &&
            st.alm_sm[`RTC_F_SEC] != e_sec[6:0]) begin
            match = 1'b0;
        end
        if (st.alm_sm[`RTC_F_MIN] != 7'h7F &&
            st.alm_sm[`RTC_F_MIN] != e_min[6:0]) begin
            match = 1'b0;
        end
        if (st.alm_hw[`RTC_F_AWDAY] != 4'hF &&
            st.alm_hw[`RTC_F_AWDAY] != {1'b0, st.wday}) begin
            match = 1'b0;
        end
        if (st.alm_hw[`RTC_F_HR] != 5'h1F &&
            (st.alm_hw[`RTC_F_HR] != hr_code[4:0] ||
             ((st.twelve || st.bcd) &&
              st.alm_hw[`RTC_B_PM] != hr_code[5]))) begin
            match = 1'b0;
        end
        if (st.alm_md[`RTC_F_DAY] != 6'h3F &&
            st.alm_md[`RTC_F_DAY] != e_day[5:0]) begin
            match = 1'b0;
        end
        if (st.alm_md[`RTC_F_MON] != 5'h1F &&
            st.alm_md[`RTC_F_MON] != e_mon[4:0]) begin
            match = 1'b0;
        end
    end

    assign idx     = apb_req.paddr[9:2];
    assign setup   = apb_req.psel && !apb_req.penable;
    assign wr      = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign wr_time = wr && (idx >= `RTC_IDX_TSM) && (idx <= `RTC_IDX_TYR);
    assign mlen    = days_in(st.mon, st.year);
    assign hit     = (apb_req.paddr[11:10] == 2'h0) &&
                     (((idx >= `RTC_IDX_TSM) && (idx <= `RTC_IDX_CTL)) ||
                      (idx == `RTC_IDX_AUX));

    always_comb begin
        logic       c_min;
        logic       c_hr;
        logic       c_day;
        logic       c_mon;
        logic       c_yr;
        logic [6:0] h;
        logic [15:0] wd;
        c_min = st.sec >= `RTC_SEC_MAX;
        c_hr  = c_min && (st.min >= `RTC_SEC_MAX);
        c_day = c_hr && (st.hr >= `RTC_HR_MAX);
        c_mon = c_day && (st.day >= mlen);
        c_yr  = c_mon && (st.mon >= `RTC_MON_MAX);
        h     = '0;
        wd    = apb_req.pwdata[15:0];
        next_st = st;
        next_st.sec_evt = 1'b0;
        // Status follows the request one cycle later, once the logic obeys.
        next_st.stopped = st.stop;
        next_st.alm_stopped = st.alm_stop;
        next_st.alm_evt = match && !st.alm_stopped;
        if (tick) begin
            next_st.sec_evt = 1'b1;
            next_st.sec = c_min ? 7'h00 : st.sec + 7'h01;
            if (c_min) begin
                next_st.min = c_hr ? 7'h00 : st.min + 7'h01;
            end
            if (c_hr) begin
                next_st.hr = c_day ? 5'h00 : st.hr + 5'h01;
            end
            if (c_day) begin
                next_st.wday = (st.wday >= `RTC_WDAY_MAX) ?
                               `RTC_WDAY_RST : st.wday + 3'h1;
                next_st.day = c_mon ? `RTC_DAY_RST : st.day + 6'h01;
            end
            if (c_mon) begin
                next_st.mon = c_yr ? `RTC_MON_RST : st.mon + 5'h01;
            end
            if (c_yr) begin
                next_st.year = (st.year >= `RTC_YEAR_MAX) ?
                               7'h00 : st.year + 7'h01;
            end
        end
        // A write lands after the tick so software always has the last word.
        if (wr && hit) begin
            case (idx)
                `RTC_IDX_TSM: begin
                    next_st.sec = dec({1'b0, wd[`RTC_F_SEC]}, st.bcd);
                    next_st.min = dec({1'b0, wd[`RTC_F_MIN]}, st.bcd);
                end
                `RTC_IDX_THW: begin
                    next_st.wday = wd[`RTC_F_WDAY];
                    if (st.twelve) begin
                        h = dec({3'h0, wd[`RTC_F_HR]}, st.bcd);
                        if (h == 7'({`RTC_HR_NOON})) begin
                            h = 7'h00;
                        end
                        if (wd[`RTC_B_PM]) begin
                            h = h + 7'({`RTC_HR_NOON});
                        end
                    end else begin
                        h = dec({2'h0, wd[5:0]}, st.bcd);
                    end
                    next_st.hr = h[4:0];
                end
                `RTC_IDX_TMD: begin
                    h = dec({2'h0, wd[`RTC_F_DAY]}, st.bcd);
                    next_st.day = h[5:0];
                    h = dec({3'h0, wd[`RTC_F_MON]}, st.bcd);
                    next_st.mon = h[4:0];
                end
                `RTC_IDX_TYR: next_st.year = dec(wd[`RTC_F_YEAR], st.bcd);
                `RTC_IDX_ASM: next_st.alm_sm = wd;
                `RTC_IDX_AHW: next_st.alm_hw = wd;
                `RTC_IDX_AMD: next_st.alm_md = wd;
                `RTC_IDX_CTL: begin
                    next_st.bcd      = wd[`RTC_B_BCD];
                    next_st.twelve   = wd[`RTC_B_TWELVE];
                    next_st.stop     = wd[`RTC_B_STOP];
                    next_st.alm_stop = wd[`RTC_B_ASTOP];
                end
                `RTC_IDX_AUX: next_st.count_enable = wd[`RTC_B_CNT_EN];
                default: next_st.pslverr = 1'b0;
            endcase
        end
        // Read data is caught in setup so it stands through the access phase.
        if (setup) begin
            next_st.pslverr = !hit;
            next_st.prdata = '0;
            if (!apb_req.pwrite && hit) begin
                case (idx)
                    `RTC_IDX_TSM: next_st.prdata[15:0] = v_tsm;
                    `RTC_IDX_THW: next_st.prdata[15:0] = v_thw;
                    `RTC_IDX_TMD: next_st.prdata[15:0] = v_tmd;
                    `RTC_IDX_TYR: next_st.prdata[15:0] = v_tyr;
                    `RTC_IDX_ASM: next_st.prdata[15:0] = st.alm_sm;
                    `RTC_IDX_AHW: next_st.prdata[15:0] = st.alm_hw;
                    `RTC_IDX_AMD: next_st.prdata[15:0] = st.alm_md;
                    `RTC_IDX_CTL: next_st.prdata[15:0] = v_ctl;
                    default: next_st.prdata[`RTC_B_CNT_EN] = st.count_enable;
                endcase
            end
        end else if (!apb_req.psel || apb_req.penable) begin
            next_st.pslverr = apb_req.psel && st.pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st              <= '0;
            st.wday         <= `RTC_WDAY_RST;
            st.day          <= `RTC_DAY_RST;
            st.mon          <= `RTC_MON_RST;
            st.count_enable <= 1'b1;
            st.alm_stop     <= 1'b1;
            st.alm_stopped  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Zero wait states keep the slave simple; every access ends at once.
    assign apb_rsp.prdata  = st.prdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = st.pslverr;
    assign seconds_event   = st.sec_evt;
    assign alarm_event     = st.alm_evt;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_last_second;
        tick && st.sec == `RTC_SEC_MAX && !wr_time;
    endsequence

    sequence s_alarm_armed;
        !st.alm_stopped && match;
    endsequence

    a_tick_event:
    assert property (tick |-> $past(run) ##1 seconds_event)
        else $error("seconds event missing after tick");

    a_time_holds:
    assert property (!tick && !wr_time |=>
                     $stable(st.sec) && $stable(st.min) && $stable(st.hr))
        else $error("time changed without tick or write");

    a_enable_gate:
    assert property (!st.count_enable |=> !tick)
        else $error("tick while counting disabled");

    a_stop_status:
    assert property (st.stop ##1 st.stop |-> st.stopped && !tick)
        else $error("counter stop not reported or ignored");

    a_alarm_status:
    assert property ($rose(st.alm_stop) |=> st.alm_stopped ##1 !alarm_event)
        else $error("alarm stop not honoured");

    a_alarm_fire:
    assert property (s_alarm_armed |=> alarm_event)
        else $error("alarm event missing on match");

    a_alarm_false:
    assert property (!match |=> !alarm_event)
        else $error("alarm event without match");

    a_sec_wrap:
    assert property (s_last_second |=> st.sec == 7'h00 &&
                     st.min != $past(st.min))
        else $error("seconds did not carry into minutes");

    a_field_range:
    assert property (st.sec <= `RTC_SEC_MAX && st.min <= `RTC_SEC_MAX &&
                     st.hr <= `RTC_HR_MAX)
        else $error("time field out of range");

    a_weekday_range:
    assert property (!wr_time |-> ##1 st.wday != 3'h0)
        else $error("weekday left its range");

    a_century:
    assert property (st.bcd |-> v_tyr[`RTC_F_CENT] == 6'h20)
        else $error("century field not twenty");

    a_day_wrap:
    assert property (tick && st.day == mlen && st.hr == `RTC_HR_MAX &&
                     st.min == `RTC_SEC_MAX && st.sec == `RTC_SEC_MAX &&
                     !wr_time |=> st.day == `RTC_DAY_RST)
        else $error("day of month did not wrap");
endmodule : rtc_core
`default_nettype wire

// file: logic/rtc_defines.svh
// Purpose: Offsets, field positions, reset values and timing of the clock.
// Assumes: One 50 MHz APB clock; register index times four is the address.
// Notes:   Register offsets are word indices; the bus address is four times.
// Contract
// - Clock advances only while count enable is one; it resets to one.
// - Control bit 15 picks binary (0) or BCD (1) coding; resets to 0.
// - Control bit 14 picks 12-hour mode with AM/PM in hours top bit.
// - Seconds in bits 6:0, minutes in 14:8, both 0 to 59, reset 0.
// - Weekday in bits 10:8, 1 to 7 with 1 Sunday, resets to 1.
// - Bit 5 of hour register is the PM flag, meaningful in 12-hour mode.
// - Hours in bits 4:0 (5:0 in 24-hour BCD), 0-23 or 1-12 by mode, reset 0.
// - Month in 12:8 (1-12), day in 5:0 (1-31), both reset to 1.
// - Century field in bits 13:8 of year register is fixed at 20.
// - Year units in bits 7:0, 0 to 99, reset 0.
// - Each seconds increment raises seconds event; time then holds a second.
// - Control bit 11 halts seconds counter; bit 10 reports it stopped.
// - An alarm field of all ones is left out of the comparison.
// - Alarm event rises when all compared alarm fields equal the time.
// - Alarm minutes in 14:8, alarm seconds in 6:0, reset 0.
// - Alarm weekday is four bits at 11:8, 1 to 7.
// - Alarm hours in 4:0, alarm PM flag in bit 5.
// - Alarm month in 12:8, alarm day in 5:0, both reset 0.
// - Alarm persists for every second in which the comparison holds.
// - Control bit 9 stops alarms; bit 8 reports them stopped; reset 1.
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

`define RTC_IDX_TSM      8'h10
`define RTC_IDX_THW      8'h11
`define RTC_IDX_TMD      8'h12
`define RTC_IDX_TYR      8'h13
`define RTC_IDX_ASM      8'h14
`define RTC_IDX_AHW      8'h15
`define RTC_IDX_AMD      8'h16
`define RTC_IDX_CTL      8'h17
`define RTC_IDX_AUX      8'h0C

`define RTC_F_SEC        6:0
`define RTC_F_MIN        14:8
`define RTC_F_WDAY       10:8
`define RTC_F_AWDAY      11:8
`define RTC_F_HR         4:0
`define RTC_B_PM         5
`define RTC_F_DAY        5:0
`define RTC_F_MON        12:8
`define RTC_F_CENT       13:8
`define RTC_F_YEAR       7:0
`define RTC_B_BCD        15
`define RTC_B_TWELVE     14
`define RTC_B_STOP       11
`define RTC_B_STOPPED    10
`define RTC_B_ASTOP      9
`define RTC_B_ASTOPPED   8
`define RTC_B_CNT_EN     11

`define RTC_SEC_MAX      7'h3B
`define RTC_HR_MAX       5'h17
`define RTC_HR_NOON      5'h0C
`define RTC_WDAY_MAX     3'h7
`define RTC_WDAY_RST     3'h1
`define RTC_DAY_RST      6'h01
`define RTC_MON_RST      5'h01
`define RTC_MON_MAX      5'h0C
`define RTC_YEAR_MAX     7'h63
`define RTC_CENTURY      7'h14

`define RTC_SECOND_MS    1000
`define RTC_CLK_KHZ      50000
`define RTC_TICK_CYCLES  (`RTC_SECOND_MS * `RTC_CLK_KHZ)

`endif

// file: logic/rtc_pkg.sv
// Purpose: Types shared by the calendar clock modules.
// Assumes: Field widths match the register layout.
// Notes:   APB signals travel as request and response structs.
package rtc_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rtc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rtc_apb_rsp_t;

    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } rtc_tick_state_t;

    typedef struct packed {
        logic [6:0]  sec;
        logic [6:0]  min;
        logic [4:0]  hr;
        logic [2:0]  wday;
        logic [5:0]  day;
        logic [4:0]  mon;
        logic [6:0]  year;
        logic [15:0] alm_sm;
        logic [15:0] alm_hw;
        logic [15:0] alm_md;
        logic        bcd;
        logic        twelve;
        logic        stop;
        logic        stopped;
        logic        alm_stop;
        logic        alm_stopped;
        logic        count_enable;
        logic [31:0] prdata;
        logic        pslverr;
        logic        sec_evt;
        logic        alm_evt;
    } rtc_state_t;
endpackage : rtc_pkg

// file: logic/rtc_tick_gen.sv
// Purpose: One-second tick from the bus clock.
// Assumes: run comes from logic on the same clock.
// Notes:   Dropping run clears the count so a restart gives a full second.
`timescale 1ns/1ps
`default_nettype none
module rtc_tick_gen
    import rtc_pkg::*;
#(
    parameter int unsigned CYCLES = 50000000
) (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Control and tick.
    input  wire logic run,
    output logic      tick
);
    rtc_tick_state_t st;
    rtc_tick_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!run) begin
            next_st.count = 32'h0;
        end else if (st.count >= 32'(CYCLES - 1)) begin
            next_st.count = 32'h0;
            next_st.tick = 1'b1;
        end else begin
            next_st.count = st.count + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : rtc_tick_gen
`default_nettype wire

// file: testbench/rtc_core_tb_top.sv
// Purpose: Self-checking bench for the calendar clock over APB.
// Assumes: Zero-wait APB slave; a short tick period stands in for a second.
// Notes:   Every scenario is its own task; all waits are bounded.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"
module rtc_core_tb_top
    import rtc_pkg::*;
;
    // A short tick keeps the run small; reads must fit inside one tick.
    localparam int unsigned TC = 60;

    logic         pclk;
    logic         presetn;
    rtc_apb_req_t apb_req;
    rtc_apb_rsp_t apb_rsp;
    logic         seconds_event;
    logic         alarm_event;
    int           failures;
    int           comparisons;

    rtc_core #(.TICK_CYCLES(TC)) u_rtc_core (
        .pclk          (pclk),
        .presetn       (presetn),
        .apb_req       (apb_req),
        .apb_rsp       (apb_rsp),
        .seconds_event (seconds_event),
        .alarm_event   (alarm_event)
    );

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    task automatic stop_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Request is held from setup until pready is sampled high.
    task automatic apb(input logic wr_en, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rdo,
                       output logic erro);
        int n;
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, wr_en, {2'b00, idx, 2'b00}, wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 16);
        rdo = apb_rsp.prdata;
        erro = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        if (apb_rsp.pready !== 1'b1) begin
            chk("pready", 32'h1, 32'h0);
            stop_test();
        end
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, idx, wd, d, e);
    endtask : wr

    task automatic rchk(input string name, input logic [7:0] idx,
                        input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, idx, 32'h0, d, e);
        chk(name, exp, d);
        chk({name, " pslverr"}, 32'h0, {31'h0, e});
    endtask : rchk

    // Sets the stop request and polls the stopped status, bounded.
    task automatic stop_counter(input logic [31:0] ctl);
        logic [31:0] d;
        logic        e;
        int          n;
        wr(`RTC_IDX_CTL, ctl);
        n = 0;
        do begin
            apb(1'b0, `RTC_IDX_CTL, 32'h0, d, e);
            n++;
        end while (d[`RTC_B_STOPPED] !== 1'b1 && n < 10);
        chk("stopped status", 32'h1, {31'h0, d[`RTC_B_STOPPED]});
    endtask : stop_counter

    task automatic wait_sec;
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (seconds_event !== 1'b1 && n < 3 * TC);
        chk("seconds_event", 32'h1, {31'h0, seconds_event});
        if (seconds_event !== 1'b1) stop_test();
    endtask : wait_sec

    task automatic sc_reset_values;
        logic [31:0] d;
        logic        e;
        rchk("time sec min", `RTC_IDX_TSM, 32'h0000);
        rchk("time hr wday", `RTC_IDX_THW, 32'h0100);
        rchk("time mon day", `RTC_IDX_TMD, 32'h0101);
        rchk("time year", `RTC_IDX_TYR, 32'h1400);
        rchk("alarm sec min", `RTC_IDX_ASM, 32'h0000);
        rchk("alarm hr wday", `RTC_IDX_AHW, 32'h0000);
        rchk("alarm mon day", `RTC_IDX_AMD, 32'h0000);
        rchk("control", `RTC_IDX_CTL, 32'h0300);
        rchk("count enable", `RTC_IDX_AUX, 32'h0800);
        apb(1'b0, 8'h3F, 32'h0, d, e);
        chk("unmapped pslverr", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, d);
    endtask : sc_reset_values

    task automatic sc_count_enable;
        int n;
        wr(`RTC_IDX_AUX, 32'h0000);
        n = 0;
        repeat (3 * TC) begin
            @(posedge pclk);
            if (seconds_event === 1'b1) n++;
        end
        chk("ticks while disabled", 32'h0, n);
        wr(`RTC_IDX_AUX, 32'h0800);
    endtask : sc_count_enable

    // 23:59:59 on Saturday 28 February of a non-leap year rolls to 1 March.
    task automatic sc_rollover;
        stop_counter(32'h0B00);
        wr(`RTC_IDX_TSM, 32'h3B3B);
        wr(`RTC_IDX_THW, 32'h0717);
        wr(`RTC_IDX_TMD, 32'h021C);
        wr(`RTC_IDX_TYR, 32'h0003);
        wr(`RTC_IDX_CTL, 32'h0200);
        wait_sec();
        rchk("roll sec min", `RTC_IDX_TSM, 32'h0000);
        rchk("reread sec min", `RTC_IDX_TSM, 32'h0000);
        rchk("roll hr wday", `RTC_IDX_THW, 32'h0100);
        rchk("roll mon day", `RTC_IDX_TMD, 32'h0301);
        rchk("roll year", `RTC_IDX_TYR, 32'h1403);
    endtask : sc_rollover

    // 13:45:30 seen in BCD and 12-hour form, with read-only bits ignored.
    task automatic sc_bcd_twelve;
        stop_counter(32'h0B00);
        wr(`RTC_IDX_TSM, 32'h2D1E);
        wr(`RTC_IDX_THW, 32'h020D);
        wr(`RTC_IDX_CTL, 32'hCA00);
        rchk("bcd sec min", `RTC_IDX_TSM, 32'h4530);
        rchk("12h hr pm", `RTC_IDX_THW, 32'h0221);
        rchk("bcd year", `RTC_IDX_TYR, 32'h2003);
        // Noon written in 12-hour BCD must read back as 12 with PM set.
        wr(`RTC_IDX_THW, 32'h0332);
        rchk("12h noon", `RTC_IDX_THW, 32'h0332);
        rchk("bcd control", `RTC_IDX_CTL, 32'hCF00);
    endtask : sc_bcd_twelve

    task automatic sc_alarm;
        int n;
        stop_counter(32'h0A00);
        wr(`RTC_IDX_TSM, 32'h1400);
        wr(`RTC_IDX_THW, 32'h010A);
        wr(`RTC_IDX_ASM, 32'h147F);
        wr(`RTC_IDX_AHW, 32'h0F3F);
        wr(`RTC_IDX_AMD, 32'h1F3F);
        wr(`RTC_IDX_CTL, 32'h0800);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (alarm_event !== 1'b1 && n < 8);
        chk("alarm on match", 32'h1, {31'h0, alarm_event});
        rchk("alarm running", `RTC_IDX_CTL, 32'h0C00);
        wr(`RTC_IDX_CTL, 32'h0000);
        repeat (3) begin
            wait_sec();
            @(posedge pclk);
            chk("alarm held", 32'h1, {31'h0, alarm_event});
        end
        wr(`RTC_IDX_CTL, 32'h0200);
        repeat (3) @(posedge pclk);
        chk("alarm stopped", 32'h0, {31'h0, alarm_event});
        // A minute that differs must keep the alarm quiet.
        wr(`RTC_IDX_ASM, 32'h157F);
        wr(`RTC_IDX_CTL, 32'h0000);
        repeat (5) @(posedge pclk);
        chk("alarm mismatch", 32'h0, {31'h0, alarm_event});
    endtask : sc_alarm

    initial begin
        presetn = 1'b0;
        apb_req = '0;
        failures = 0;
        comparisons = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        sc_reset_values();
        sc_count_enable();
        sc_rollover();
        sc_bcd_twelve();
        sc_alarm();
        stop_test();
    end
endmodule : rtc_core_tb_top
`default_nettype wire
